// [verilog/accs_sequencer.sv]
// conversion clock selection and conversion sequencing for a sar converter
// assumes serial clock and convert start come from pins; configuration is
// driven by the serial command logic on clk
`timescale 1ns/100ps
`include "accs_consts.svh"

// Behaviour
// - conversions are paced by the internal oscillator unless the serial clock source is selected.
// - the internal oscillator runs except in deep power-down or with serial clock as source.
// - acquisition lasts at least three conversion clocks before a conversion may begin.
// - a conversion takes eighteen conversion clocks from start to result.
// - with the serial clock as source, the conversion clock is the serial clock divided by two.
// - an unsynchronised start may begin one serial clock late, giving 37 rather than 36.
// - at conversion start the input is held and stays disconnected until the end.
// - the dual-input variant has manual channel choice and auto alternation of channels 0 and 1.
// - under manual trigger the falling edge of convert start ends sampling and starts conversion.
// - under auto trigger the next conversion starts three clocks after the last, 21 per cycle.
module accs_sequencer #(
  parameter int OSC_DIV = `ACCS_OSC_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins from the host
  input wire logic sclk,
  input wire logic convert_start_n,
  // configuration
  input wire accs_pkg::accs_cfg_t cfg,
  // status and converter controls
  output accs_pkg::accs_status_t status,
  output logic osc_running,
  output logic conversion_clock,
  output logic hold
);

  // pin synchronisers; first stage read only by the second
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
    end
    else
    begin
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg <= convert_start_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
    end
  end

  logic sclk_rise;
  logic start_fall;
  assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  assign start_fall = ~cs_s2_reg & cs_s3_reg;

  // internal oscillator modelled as a divider of clk
  logic osc_en;
  logic [3:0] osc_cnt_reg;
  logic osc_tick;
  assign osc_en = ~cfg.deep_powerdown & ~cfg.sclk_source;
  assign osc_tick = osc_en && (osc_cnt_reg == 4'(OSC_DIV - 1));
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      osc_cnt_reg <= 4'h0;
    else if (!osc_en || osc_tick)
      osc_cnt_reg <= 4'h0;
    else
      osc_cnt_reg <= osc_cnt_reg + 4'h1;
  end

  // serial clock halved: every second rising edge is a conversion clock
  logic sclk_half_reg;
  logic sclk_tick;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sclk_half_reg <= 1'b0;
    else if (sclk_rise)
      sclk_half_reg <= ~sclk_half_reg;
  end
  assign sclk_tick = sclk_rise & sclk_half_reg;

  logic conversion_clock_tick;
  // serial clock is blocked from the converter in deep power-down too
  assign conversion_clock_tick = !cfg.deep_powerdown && (cfg.sclk_source ? sclk_tick : osc_tick);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      conversion_clock <= 1'b0;
    else if (conversion_clock_tick)
      conversion_clock <= ~conversion_clock;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      osc_running <= 1'b0;
    else
      osc_running <= osc_en;
  end

  // a start is latched and begins on the next conversion clock, so an
  // unaligned strobe in serial mode costs one extra serial clock
  logic start_pend_reg;
  logic [`ACCS_CNT_W-1:0] cnt_reg;
  accs_pkg::accs_state_t state_reg;
  logic acq_met;
  logic begin_conv;
  assign acq_met = (state_reg == accs_pkg::ACCS_ACQ) && (cnt_reg >= `ACCS_ACQ_CCLKS);
  // acq_met again so a stale pending start can never cut acquisition short
  assign begin_conv = conversion_clock_tick && start_pend_reg && acq_met;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      start_pend_reg <= 1'b0;
    else if (cfg.auto_trigger || cfg.deep_powerdown)
      start_pend_reg <= 1'b0;
    else if (start_fall && acq_met)
      start_pend_reg <= 1'b1;
    else if (begin_conv)
      start_pend_reg <= 1'b0;
  end

  logic conv_end;
  logic auto_start;
  assign conv_end = (state_reg == accs_pkg::ACCS_CONV) && conversion_clock_tick
    && (cnt_reg == `ACCS_CONV_CCLKS - 5'h01);
  assign auto_start = cfg.auto_trigger && conversion_clock_tick && (state_reg == accs_pkg::ACCS_ACQ)
    && (cnt_reg >= `ACCS_ACQ_CCLKS - 5'h01);
  // >= so an acquisition already past three clocks (auto just enabled) starts on the next one

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= accs_pkg::ACCS_IDLE;
      cnt_reg <= '0;
    end
    else if (cfg.deep_powerdown)
    begin
      state_reg <= accs_pkg::ACCS_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      case (state_reg)
        accs_pkg::ACCS_IDLE:
        begin
          state_reg <= accs_pkg::ACCS_ACQ;
          cnt_reg <= '0;
        end
        accs_pkg::ACCS_ACQ:
        begin
          if (begin_conv || auto_start)
          begin
            state_reg <= accs_pkg::ACCS_CONV;
            cnt_reg <= '0;
          end
          else if (conversion_clock_tick && !acq_met)
            cnt_reg <= cnt_reg + 5'h01;
        end
        accs_pkg::ACCS_CONV:
        begin
          if (conv_end)
          begin
            state_reg <= accs_pkg::ACCS_ACQ;
            cnt_reg <= '0;
          end
          else if (conversion_clock_tick)
            cnt_reg <= cnt_reg + 5'h01;
        end
        default:
        begin
          state_reg <= accs_pkg::ACCS_IDLE;
          cnt_reg <= '0;
        end
      endcase
    end
  end

  // hold from conversion start until its last clock
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hold <= 1'b0;
    else if (begin_conv || auto_start)
      hold <= 1'b1;
    else if (conv_end || cfg.deep_powerdown)
      hold <= 1'b0;
  end

  // channel: manual choice or alternation taken at each conversion end
  logic chan_reg;
  logic auto_chan_prev_reg;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chan_reg <= 1'b0;
      auto_chan_prev_reg <= 1'b0;
    end
    else
    begin
      auto_chan_prev_reg <= cfg.auto_channel;
      if (!cfg.auto_channel)
        chan_reg <= cfg.manual_channel;
      else if (!auto_chan_prev_reg)
        chan_reg <= 1'b0;
      else if (conv_end)
        chan_reg <= ~chan_reg;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status <= '0;
    else
    begin
      status.sampling <= (state_reg == accs_pkg::ACCS_ACQ);
      status.converting <= (state_reg == accs_pkg::ACCS_CONV);
      status.channel <= chan_reg;
      status.done <= conv_end;
    end
  end

endmodule

// [inc/accs_consts.svh]
// timing and count constants for the conversion clock sequencer
// assumes inclusion by bare name from design files
`ifndef ACCS_CONSTS_SVH
`define ACCS_CONSTS_SVH
`define ACCS_ACQ_CCLKS 5'h03
`define ACCS_CONV_CCLKS 5'h12
`define ACCS_CYCLE_CCLKS 5'h15
`define ACCS_OSC_DIV 4'h4
`define ACCS_CNT_W 5
`endif

// [inc/accs_pkg.sv]
// types shared by the conversion clock sequencer
// assumes accs_consts.svh is on the include path
package accs_pkg;
  typedef enum logic [1:0] {
    ACCS_IDLE,
    ACCS_ACQ,
    ACCS_CONV
  } accs_state_t;

  typedef struct packed {
    logic sclk_source;
    logic auto_trigger;
    logic auto_channel;
    logic manual_channel;
    logic deep_powerdown;
  } accs_cfg_t;

  typedef struct packed {
    logic sampling;
    logic converting;
    logic channel;
    logic done;
  } accs_status_t;
endpackage

// [test/accs_sequencer_asserts.sv]
// checker for sequencer port timing
// assumes bind onto accs_sequencer
`timescale 1ns/100ps
module accs_chk (
  // watched ports
  input wire logic clk,
  input wire logic rstn,
  input wire accs_pkg::accs_cfg_t cfg,
  input wire accs_pkg::accs_status_t status,
  input wire logic osc_running,
  input wire logic conversion_clock,
  input wire logic hold
);
  logic hq_reg;
  logic cq_reg;
  logic [7:0] tk_reg;
  wire off = cfg.deep_powerdown | cfg.sclk_source;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ticks since hold last moved; saturates so long idles never wrap
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      hq_reg <= 1'b0;
      cq_reg <= 1'b0;
      tk_reg <= 8'h00;
    end
    else
    begin
      hq_reg <= hold;
      cq_reg <= conversion_clock;
      if (hold != hq_reg)
        tk_reg <= 8'h00;
      else if (conversion_clock != cq_reg && tk_reg != 8'hff)
        tk_reg <= tk_reg + 8'h01;
    end
  AST_OSC_OFF: assert property (off [*3] |-> !osc_running)
    else $error("osc runs");
  AST_OSC_ON: assert property ((!off) [*3] |-> osc_running)
    else $error("osc stopped");
  AST_CONVERSION_CLOCK_STILL: assert property (cfg.deep_powerdown [*3] |-> $stable(conversion_clock))
    else $error("clock moves");
  // the tick that moves hold is not yet in tk_reg, so it is added here
  AST_ACQ_MIN: assert property ($rose(hold) |->
    ({1'b0, tk_reg} + 9'(conversion_clock != cq_reg)) >= 9'h003)
    else $error("short acq");
  AST_CONV_LEN: assert property ($fell(hold) && !cfg.deep_powerdown |->
    ({1'b0, tk_reg} + 9'(conversion_clock != cq_reg)) == 9'h012)
    else $error("conv length");
  AST_DONE_END: assert property ($fell(hold) && !cfg.deep_powerdown |-> ##[0:2] status.done)
    else $error("no done");
  AST_DONE_ONE: assert property (status.done |=> !status.done)
    else $error("long done");
  AST_HELD: assert property (hold && $past(hold) |->
    !status.sampling && status.converting)
    else $error("samples in hold");
  AST_AUTO_NEXT: assert property ($fell(hold) && cfg.auto_trigger && !off |->
    ##[8:24] ($rose(hold) || !cfg.auto_trigger))
    else $error("no auto start");
endmodule

bind accs_sequencer accs_chk u_accs_chk (.clk(clk), .rstn(rstn), .cfg(cfg), .status(status),
  .osc_running(osc_running), .conversion_clock(conversion_clock), .hold(hold));

// [test/accs_host.sv]
// host model: serial clock and convert start
// assumes 5 ns clk; sclk is clk/8
`timescale 1ns/100ps
module accs_host (
  // bench side
  input wire logic clk,
  input wire logic run,
  // pins
  output logic sclk,
  output logic convert_start_n
);
  logic [2:0] ph_reg = 3'h0;
  initial
  begin
    sclk = 1'b0;
    convert_start_n = 1'b1;
  end
  // stands still outside run
  always @(posedge clk)
    if (run)
    begin
      ph_reg <= ph_reg + 3'h1;
      sclk <= ph_reg[2];
    end
  task automatic strobe();
    @(posedge clk iff (ph_reg == 3'h0 || !run)); // 20 ns ahead of sclk rise
    convert_start_n <= 1'b0;
    repeat (8) @(posedge clk); // 40 ns low
    convert_start_n <= 1'b1;
  endtask
endmodule

// [test/adc_conversion_clock_sequencer_tb_top.sv]
// bench for accs_sequencer
// assumes host model and checker compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %0t %h %h", $time, g, e); end end
module adc_conversion_clock_sequencer_tb_top;
  localparam int OD = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic run = 1'b0;
  logic sclk;
  logic convert_start_n;
  accs_pkg::accs_cfg_t cfg = '0;
  accs_pkg::accs_status_t status;
  logic osc_running;
  logic conversion_clock;
  logic hold;
  int failures = 0;
  int n_checks = 0;
  int gap;
  int len;
  logic ch;
  logic c0;
  always #2.5 clk = ~clk;
  accs_host u_accs_host (.clk(clk), .run(run), .sclk(sclk), .convert_start_n(convert_start_n));
  accs_sequencer #(.OSC_DIV(OD)) u_accs_sequencer (.clk(clk), .rstn(rstn), .sclk(sclk),
    .convert_start_n(convert_start_n), .cfg(cfg), .status(status),
    .osc_running(osc_running), .conversion_clock(conversion_clock), .hold(hold));
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // clk edges spanned by a number of conversion ticks of a given period
  function automatic int clks(input int ticks, input int per);
    return ticks * per;
  endfunction
  // low cycles before a conversion, then its length in clk
  task automatic meas(input bit go);
    if (go)
      fork
        u_accs_host.strobe();
      join_none
    gap = 0;
    while (hold !== 1'b1 && gap < 4000)
    begin
      @(posedge clk);
      gap++;
    end
    ch = status.channel;
    len = 0;
    while (hold === 1'b1 && len < 4000)
    begin
      @(posedge clk);
      len++;
    end
  endtask
  initial
  begin
    void'($urandom(32'h3549_6b82));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 3; i++)
    begin
      cfg.manual_channel <= 1'($urandom);
      repeat ($urandom_range(30, 90)) @(posedge clk);
      // restart mid-conversion must be ignored
      if (i == 1)
        fork
          begin
            repeat (40) @(posedge clk);
            u_accs_host.strobe();
          end
        join_none
      meas(1'b1);
      `CHK(len, clks(18, OD))
      `CHK(ch, cfg.manual_channel)
    end
    $display("test manual done");
    cfg.deep_powerdown <= 1'b1;
    repeat (10) @(posedge clk);
    c0 = conversion_clock;
    repeat (20) @(posedge clk);
    `CHK(osc_running, 1'b0)
    `CHK(conversion_clock, c0)
    cfg.deep_powerdown <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK(osc_running, 1'b1)
    $display("test powerdown done");
    cfg.auto_trigger <= 1'b1;
    cfg.auto_channel <= 1'b1;
    meas(1'b0);
    `CHK(ch, 1'b0)
    meas(1'b0);
    c0 = ch;
    meas(1'b0);
    `CHK(gap, clks(3, OD))
    `CHK(len, clks(18, OD))
    `CHK(ch, ~c0)
    cfg <= '0;
    $display("test auto done");
    repeat (100) @(posedge clk);
    cfg.sclk_source <= 1'b1;
    run <= 1'b1;
    repeat (40) @(posedge clk);
    meas(1'b1);
    `CHK(len, clks(18, 2 * 8))
    `CHK(osc_running, 1'b0)
    $display("test sclk done");
    wrap_up();
  end
  initial
  begin
    #50000;
    failures++;
    wrap_up();
  end
endmodule
